// >>> rtl/nma_pkg.sv
`default_nettype none
package nma_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int COEF_W = 10;
  localparam int CAS_W = 16;
  localparam int PROD_W = 22;
  localparam int ACC_W = 26;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Rounding: result field position and half-LSB constant
  // ----------------------------------------------------------------
  localparam int MAT_SHIFT = 10;
  localparam int FIR_SHIFT = 6;
  localparam logic [ACC_W-1:0] MAT_HALF = 26'h0000200;
  localparam logic [ACC_W-1:0] FIR_HALF = 26'h0000020;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NMA_MATRIX = 2'h0,
    NMA_FIR9 = 2'h1,
    NMA_CONV33 = 2'h2,
    NMA_CONV42 = 2'h3
  } nma_mode_type;
  localparam logic [1:0] CWE_HOLD = 2'h0;
  localparam nma_mode_type MODE_RST = NMA_MATRIX;

  // Three data words taken together
  typedef struct packed {
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] c;
  } nma_words_type;

  // Whole state of the array control
  typedef struct packed {
    nma_mode_type mode;                      // Registered configuration
    logic [2:0][2:0][COEF_W-1:0] coef;       // [port][set], no reset
    logic [2:0][2:0][DATA_W-1:0] tap;        // [row][position]
    logic [2:0][2:0][PROD_W-1:0] prod;       // Products
    logic [2:0][ACC_W-1:0] part;             // Row or column sums
    logic [2:0][ACC_W-1:0] col;              // Final sums
    logic [2:0][CAS_W-1:0] cas;              // Cascade delay line
    logic [DATA_W-1:0] x;                    // First result pins
    logic [DATA_W-1:0] y;                    // Second result pins
    logic [DATA_W-1:0] z;                    // Third result pins
    logic drive;                             // Shared pins driven
  } nma_state_type;
endpackage : nma_pkg
`default_nettype wire

// >>> rtl/nma_top.sv
`default_nettype none

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module nma_fifo #(
  parameter int W = 36,
  parameter int D = 4
) (
  input wire logic clk_sys,           // System clock
  input wire logic rst,               // Synchronous reset
  input wire logic in_valid,          // Source offers a word
  output logic in_ready,              // Room for a word
  input wire logic [W-1:0] in_data,   // Word from source
  output logic out_valid,             // Word available
  input wire logic out_ready,         // Drain takes the word
  output logic [W-1:0] out_data       // Oldest word
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;   // Storage
    logic [AW-1:0] rd;          // Read pointer
    logic [AW-1:0] wr;          // Write pointer
    logic [CW-1:0] cnt;         // Words held
  } nma_fifo_state_type;

  nma_fifo_state_type st_ff;
  nma_fifo_state_type nxt_st;
  logic push;
  logic pop;

  // Pointer step with wrap at depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : step

  assign in_ready = (st_ff.cnt != CW'(D));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = st_ff.mem[st_ff.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state: write, read, count
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr = step(st_ff.wr);
    end
    if (pop) begin
      nxt_st.rd = step(st_ff.rd);
    end
    if (push && !pop) begin
      nxt_st.cnt = CW'(st_ff.cnt + 1'b1);
    end else if (pop && !push) begin
      nxt_st.cnt = CW'(st_ff.cnt - 1'b1);
    end
    if (rst) begin
      nxt_st.rd = '0;
      nxt_st.wr = '0;
      nxt_st.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    st_ff <= nxt_st;
  end
endmodule : nma_fifo

// ------------------------------------------------------------------
// Nine-multiplier array
// ------------------------------------------------------------------
module nma_top (
  input wire logic CLK_SYS,                               // Clock
  input wire logic RST,                                   // Sync reset
  input wire nma_pkg::nma_mode_type CONFIGURATION_SELECT, // Mode
  input wire logic [1:0] COEFFICIENT_SET_WRITE_SELECT,    // Set to load
  input wire logic [9:0] FIRST_COEFFICIENT_PORT,          // Port one
  input wire logic [9:0] SECOND_COEFFICIENT_PORT,         // Port two
  input wire logic [9:0] THIRD_COEFFICIENT_PORT,          // Port three
  input wire nma_pkg::nma_words_type SAMPLE_IN,           // Data words
  input wire logic SAMPLE_VALID,                          // Words valid
  output logic SAMPLE_READY,                              // FIFO room
  input wire logic PROCESS_HOLD,                          // Stall array
  input wire logic [11:0] FIRST_RESULT_OR_CASCADE_HIGH_PINS_I,  // In
  output logic [11:0] FIRST_RESULT_OR_CASCADE_HIGH_PINS_O,      // Out
  output logic [11:0] FIRST_RESULT_OR_CASCADE_HIGH_PINS_OE_N,   // Enable
  input wire logic [3:0] SECOND_RESULT_UPPER_PINS_I,      // In
  output logic [3:0] SECOND_RESULT_UPPER_PINS_O,          // Out
  output logic [3:0] SECOND_RESULT_UPPER_PINS_OE_N,       // Enable
  output logic [3:0] SECOND_RESULT_MIDDLE_PINS,           // Output only
  output logic [3:0] SECOND_RESULT_LOWER_PINS,            // Y or cascade
  output logic [11:0] THIRD_RESULT_OR_CASCADE_HIGH_PINS   // Z or cascade
);
  import nma_pkg::*;

  nma_state_type st_ff;
  nma_state_type nxt_st;
  nma_words_type word;                  // Oldest FIFO entry
  logic word_valid;                     // FIFO not empty
  logic adv;                            // Pipeline advances
  logic [CAS_W-1:0] cascade_input_word; // Cascade from pins
  logic [CAS_W-1:0] cascade_output_word;// Rounded filter word
  logic [ACC_W-1:0] acc_f;              // Filter accumulator
  logic [2:0][ACC_W-1:0] acc_m;         // Matrix accumulators
  logic [2:0][DATA_W-1:0] mat_word;     // Rounded matrix words

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Signed data times signed coefficient
  function automatic logic [PROD_W-1:0] mul(input logic [DATA_W-1:0] d,
                                            input logic [COEF_W-1:0] k);
    logic signed [PROD_W-1:0] r;
    r = $signed(d) * $signed(k);
    mul = r;
  endfunction : mul

  // Sign extend a product to accumulator width
  function automatic logic [ACC_W-1:0] widen(input logic [PROD_W-1:0] p);
    widen = {{(ACC_W-PROD_W){p[PROD_W-1]}}, p};
  endfunction : widen

  // Place cascade word at the filter result position
  function automatic logic [ACC_W-1:0] align(input logic [CAS_W-1:0] c);
    align = {{(ACC_W-CAS_W-FIR_SHIFT){c[CAS_W-1]}}, c,
             {FIR_SHIFT{1'b0}}};
  endfunction : align

  // ----------------------------------------------------------------
  // Input buffering
  // ----------------------------------------------------------------
  nma_fifo #(
    .W($bits(nma_words_type)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(CLK_SYS),
    .rst(RST),
    .in_valid(SAMPLE_VALID),
    .in_ready(SAMPLE_READY),
    .in_data(SAMPLE_IN),
    .out_valid(word_valid),
    .out_ready(adv),
    .out_data(word)
  );

  assign adv = word_valid & ~PROCESS_HOLD;
  assign cascade_input_word = {FIRST_RESULT_OR_CASCADE_HIGH_PINS_I,
                               SECOND_RESULT_UPPER_PINS_I};

  // Half-LSB rounding of final sums
  always_comb begin
    acc_f = st_ff.col[0] + align(st_ff.cas[2]) + FIR_HALF;
    cascade_output_word = acc_f[FIR_SHIFT +: CAS_W];
    for (int j = 0; j < 3; j++) begin
      acc_m[j] = st_ff.col[j] + MAT_HALF;
      mat_word[j] = acc_m[j][MAT_SHIFT +: DATA_W];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Mode and pin direction follow the select one edge later
    nxt_st.mode = CONFIGURATION_SELECT;
    nxt_st.drive = (CONFIGURATION_SELECT == NMA_MATRIX);
    // Coefficient load, one set per clock
    if (COEFFICIENT_SET_WRITE_SELECT != CWE_HOLD) begin
      nxt_st.coef[0][COEFFICIENT_SET_WRITE_SELECT - 2'h1] =
        FIRST_COEFFICIENT_PORT;
      nxt_st.coef[1][COEFFICIENT_SET_WRITE_SELECT - 2'h1] =
        SECOND_COEFFICIENT_PORT;
      nxt_st.coef[2][COEFFICIENT_SET_WRITE_SELECT - 2'h1] =
        THIRD_COEFFICIENT_PORT;
    end
    if (adv) begin
      // Tap registers
      case (st_ff.mode)
        NMA_MATRIX: begin
          nxt_st.tap[0][0] = word.a;
          nxt_st.tap[1][0] = word.b;
          nxt_st.tap[2][0] = word.c;
        end
        default: begin
          for (int r = 0; r < 3; r++) begin
            nxt_st.tap[r][2] = st_ff.tap[r][1];
            nxt_st.tap[r][1] = st_ff.tap[r][0];
          end
          nxt_st.tap[0][0] = word.a;
          nxt_st.tap[1][0] = word.b;
          nxt_st.tap[2][0] = word.c;
          if (st_ff.mode == NMA_FIR9) begin
            // B enters row three, then row two; row one still takes A
            nxt_st.tap[2][0] = word.b;
            nxt_st.tap[1][0] = st_ff.tap[2][2];
          end else if (st_ff.mode == NMA_CONV42) begin
            // Two input rows; row three extends row two
            nxt_st.tap[2][0] = st_ff.tap[1][2];
          end
        end
      endcase
      // Products: matrix uses columns, filters use taps
      for (int r = 0; r < 3; r++) begin
        for (int p = 0; p < 3; p++) begin
          if (st_ff.mode == NMA_MATRIX) begin
            nxt_st.prod[r][p] = mul(st_ff.tap[r][0], st_ff.coef[r][p]);
          end else begin
            nxt_st.prod[r][p] = mul(st_ff.tap[r][p], st_ff.coef[r][2-p]);
          end
        end
      end
      if (st_ff.mode == NMA_CONV42) begin
        nxt_st.prod[2][1] = '0;
      end
      // Partial sums
      for (int j = 0; j < 3; j++) begin
        if (st_ff.mode == NMA_MATRIX) begin
          nxt_st.part[j] = widen(st_ff.prod[0][j]) +
            widen(st_ff.prod[1][j]) + widen(st_ff.prod[2][j]);
        end else begin
          nxt_st.part[j] = widen(st_ff.prod[j][0]) +
            widen(st_ff.prod[j][1]) + widen(st_ff.prod[j][2]);
        end
      end
      // Final sums
      if (st_ff.mode == NMA_MATRIX) begin
        nxt_st.col = st_ff.part;
      end else begin
        nxt_st.col[0] = st_ff.part[0] + st_ff.part[1] + st_ff.part[2];
        nxt_st.col[1] = '0;
        nxt_st.col[2] = '0;
      end
      // Cascade delay, three stages before the output register
      nxt_st.cas[0] = cascade_input_word;
      nxt_st.cas[1] = st_ff.cas[0];
      nxt_st.cas[2] = st_ff.cas[1];
      // Result pins
      if (st_ff.mode == NMA_MATRIX) begin
        nxt_st.x = mat_word[0];
        nxt_st.y = mat_word[1];
        nxt_st.z = mat_word[2];
      end else begin
        nxt_st.x = '0;
        nxt_st.y = {8'h00, cascade_output_word[3:0]};
        nxt_st.z = cascade_output_word[15:4];
      end
    end
    // Reset clears everything except coefficients, and sets drive
    if (RST) begin
      nxt_st.mode = MODE_RST;
      nxt_st.drive = 1'b1;
      nxt_st.tap = '0;
      nxt_st.prod = '0;
      nxt_st.part = '0;
      nxt_st.col = '0;
      nxt_st.cas = '0;
      nxt_st.x = '0;
      nxt_st.y = '0;
      nxt_st.z = '0;
    end
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign FIRST_RESULT_OR_CASCADE_HIGH_PINS_O = st_ff.x;
  assign FIRST_RESULT_OR_CASCADE_HIGH_PINS_OE_N = {12{~st_ff.drive}};
  assign SECOND_RESULT_UPPER_PINS_O = st_ff.y[11:8];
  assign SECOND_RESULT_UPPER_PINS_OE_N = {4{~st_ff.drive}};
  assign SECOND_RESULT_MIDDLE_PINS = st_ff.y[7:4];
  assign SECOND_RESULT_LOWER_PINS = st_ff.y[3:0];
  assign THIRD_RESULT_OR_CASCADE_HIGH_PINS = st_ff.z;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_mode_release: assert property (
    (CONFIGURATION_SELECT != NMA_MATRIX) |=>
      (&FIRST_RESULT_OR_CASCADE_HIGH_PINS_OE_N) &&
      (&SECOND_RESULT_UPPER_PINS_OE_N))
    else $error("shared pins not released after filter select");
  a_coef_hold: assert property (
    (COEFFICIENT_SET_WRITE_SELECT == CWE_HOLD) |=> $stable(st_ff.coef))
    else $error("coefficients changed while held");
  a_coef_load: assert property (
    (COEFFICIENT_SET_WRITE_SELECT == 2'h2) |=>
      (st_ff.coef[2][1] == $past(THIRD_COEFFICIENT_PORT)) &&
      $stable(st_ff.coef[0][0]))
    else $error("coefficient set two load wrong");
  a_tap_latch: assert property (
    adv |=> st_ff.tap[0][0] == $past(word.a))
    else $error("first data word not latched");
  a_tap_shift: assert property (
    (adv && st_ff.mode != NMA_MATRIX) |=>
      st_ff.tap[0][1] == $past(st_ff.tap[0][0]))
    else $error("taps did not shift");
  a_cas_capture: assert property (
    adv |=> st_ff.cas[0] == $past(cascade_input_word))
    else $error("cascade input not captured");
  a_cas_stages: assert property (
    adv ##1 adv |=> st_ff.cas[2] == $past(st_ff.cas[0], 2))
    else $error("cascade delay line broken");
  a_cas_added: assert property (
    (adv && st_ff.mode != NMA_MATRIX && st_ff.col[0] == '0) |=>
      {THIRD_RESULT_OR_CASCADE_HIGH_PINS, SECOND_RESULT_LOWER_PINS}
        == $past(st_ff.cas[2]))
    else $error("cascade not passed to output");
  a_cascade_output_word_word: assert property (
    (adv && st_ff.mode != NMA_MATRIX) |=>
      {THIRD_RESULT_OR_CASCADE_HIGH_PINS, SECOND_RESULT_LOWER_PINS}
        == $past(cascade_output_word))
    else $error("cascade output word wrong");
  a_matrix_pins: assert property (
    (adv && st_ff.mode == NMA_MATRIX) |=>
      (FIRST_RESULT_OR_CASCADE_HIGH_PINS_O == $past(mat_word[0])) &&
      (THIRD_RESULT_OR_CASCADE_HIGH_PINS == $past(mat_word[2])))
    else $error("matrix results wrong");
  a_kc2_unused: assert property (
    (adv && st_ff.mode == NMA_CONV42) |=> st_ff.prod[2][1] == '0)
    else $error("unused multiplier not zero");

  c_fir_run: cover property (adv && st_ff.mode == NMA_FIR9 [*4]);
  c_conv42_run: cover property (adv && st_ff.mode == NMA_CONV42);
  c_fifo_full: cover property (SAMPLE_VALID && !SAMPLE_READY);
  c_coef_set3: cover property (COEFFICIENT_SET_WRITE_SELECT == 2'h3);
endmodule : nma_top
`default_nettype wire

// >>> sim/nma_cas_model.sv
`default_nettype none
// ------------------------------------------------------------------
// Upstream array feeding the shared cascade pins
// ------------------------------------------------------------------
module nma_cas_model (
  input wire logic [15:0] cas_word, // Word sent by the upstream array
  input wire logic [11:0] hi_o,     // Device level, high pins
  input wire logic [11:0] hi_oe_n,  // Device enable, high pins
  input wire logic [3:0] up_o,      // Device level, upper Y pins
  input wire logic [3:0] up_oe_n,   // Device enable, upper Y pins
  output logic [11:0] hi_i,         // Resolved wire, high pins
  output logic [3:0] up_i           // Resolved wire, upper Y pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Drive a bit only where the device has let go: never two drivers
  assign hi_i = (hi_o & ~hi_oe_n) | (cas_word[15:4] & hi_oe_n);
  assign up_i = (up_o & ~up_oe_n) | (cas_word[3:0] & up_oe_n);
endmodule : nma_cas_model
`default_nettype wire

// >>> sim/testbench.sv
`default_nettype none
// ------------------------------------------------------------------
// Bench for the nine-multiplier array
// ------------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import nma_pkg::*;
  logic clk_sys, rst, s_valid, s_ready, hold; // Clock, reset, stream
  nma_mode_type mode_sel;                     // Configuration select
  logic [1:0] cwe;                            // Set write select
  logic [2:0][9:0] kport;                     // Coefficient ports
  nma_words_type words;                       // Offered data words
  logic [11:0] hi_i, hi_o, hi_oe_n, zpins;    // Wide result pins
  logic [3:0] up_i, up_o, up_oe_n, mid, low;  // Second result pins
  logic [15:0] cas_word;                      // Upstream cascade word
  logic [9:0] coef [3][3];                    // Loaded values [port][set]
  int fails, comparisons;                     // Report counters
  // Fixed matrix test word and filter stream word
  localparam nma_words_type WM = '{a: 12'h100, b: 12'h080, c: 12'h040};
  localparam nma_words_type WF = '{a: 12'h041, b: 12'h041, c: 12'h041};

  nma_top dut_u (.CLK_SYS(clk_sys), .RST(rst),
    .CONFIGURATION_SELECT(mode_sel), .COEFFICIENT_SET_WRITE_SELECT(cwe),
    .FIRST_COEFFICIENT_PORT(kport[0]), .SECOND_COEFFICIENT_PORT(kport[1]),
    .THIRD_COEFFICIENT_PORT(kport[2]), .SAMPLE_IN(words),
    .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready), .PROCESS_HOLD(hold),
    .FIRST_RESULT_OR_CASCADE_HIGH_PINS_I(hi_i),
    .FIRST_RESULT_OR_CASCADE_HIGH_PINS_O(hi_o),
    .FIRST_RESULT_OR_CASCADE_HIGH_PINS_OE_N(hi_oe_n),
    .SECOND_RESULT_UPPER_PINS_I(up_i), .SECOND_RESULT_UPPER_PINS_O(up_o),
    .SECOND_RESULT_UPPER_PINS_OE_N(up_oe_n),
    .SECOND_RESULT_MIDDLE_PINS(mid), .SECOND_RESULT_LOWER_PINS(low),
    .THIRD_RESULT_OR_CASCADE_HIGH_PINS(zpins));
  nma_cas_model cas_u (.cas_word(cas_word), .hi_o(hi_o),
    .hi_oe_n(hi_oe_n), .up_o(up_o), .up_oe_n(up_oe_n), .hi_i(hi_i),
    .up_i(up_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare one value and report at once on a mismatch
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : check
  // Offer a word until taken; outputs read here are pre-edge values
  task automatic push(input nma_words_type w);
    s_valid <= 1'b1;
    words <= w;
    @(posedge clk_sys);
    while (s_ready !== 1'b1) @(posedge clk_sys);
  endtask : push
  // Offer the same word several times back to back
  task automatic run(input nma_words_type w, input int n);
    repeat (n) push(w);
  endtask : run
  // Matrix column result for the word WM, half-LSB rounded
  function automatic logic [11:0] mat_exp(input int k);
    return 12'((256 * coef[0][k] + 128 * coef[1][k] + 64 * coef[2][k]
                + 512) >>> 10);
  endfunction : mat_exp
  // Filter steady output for a stream of WF plus a cascade word
  function automatic logic [15:0] exp_filt(input bit c42,
                                           input logic [15:0] cas);
    int ksum;
    ksum = 0;
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 3; s++) begin
        if (!(c42 && p == 2 && s == 1)) ksum += coef[p][s];
      end
    end
    return 16'((65 * ksum + 64 * int'(cas) + 32) >>> 6);
  endfunction : exp_filt
  // Load the three sets, then leave junk on the ports while holding
  task automatic load_coefs();
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 3; p++) kport[p] <= coef[p][s];
      cwe <= 2'(s + 1);
      @(posedge clk_sys);
    end
    cwe <= CWE_HOLD;
    kport <= {3{10'h155}};
  endtask : load_coefs
  // Change mode; shared pin enables follow the taking edge exactly
  task automatic set_mode(input nma_mode_type m);
    logic [15:0] old_oe;
    old_oe = {hi_oe_n, up_oe_n};
    mode_sel <= m;
    @(posedge clk_sys);
    check({hi_oe_n, up_oe_n}, old_oe, "enable before mode edge");
    @(posedge clk_sys);
    check({hi_oe_n, up_oe_n}, (m == NMA_MATRIX) ? 16'h0 : 16'hFFFF,
          "enable after mode edge");
  endtask : set_mode

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Matrix word, exact five-edge latency on X, results on all three ports
  task automatic test_matrix();
    run('0, 8);
    push(WM);
    run('0, 5);
    check(16'(hi_o), 16'h0, "matrix result early");
    push('0);
    check(16'(hi_o), 16'(mat_exp(0)), "X result");
    check(16'({up_o, mid, low}), 16'(mat_exp(1)), "Y result");
    check(16'(zpins), 16'(mat_exp(2)), "Z result");
  endtask : test_matrix
  // Stall the array, fill the FIFO until it refuses, then drain
  // One zero word is still queued when the stall starts: three more fill it
  task automatic test_hold();
    run('0, 6);
    hold <= 1'b1;
    run(WM, 3);
    @(posedge clk_sys);
    check(16'(s_ready), 16'h0, "full FIFO still ready");
    check(16'(hi_o), 16'h0, "pins moved while stalled");
    hold <= 1'b0;
    // First drain edge is refused while full; the queued zero leads
    run('0, 6);
    check(16'(hi_o), 16'(mat_exp(0)), "result after stall");
    check(16'(s_ready), 16'h1, "FIFO not draining");
  endtask : test_hold
  // Each filter mode: steady weighted sum plus cascade word
  task automatic test_filters();
    nma_mode_type m;
    cas_word <= 16'h1234;
    for (int i = 1; i < 4; i++) begin
      m = nma_mode_type'(i);
      set_mode(m);
      run(WF, 20);
      check({zpins, low}, exp_filt(m == NMA_CONV42, 16'h1234),
            "filter sum");
      check(16'(mid), 16'h0, "middle pins in filter mode");
    end
  endtask : test_filters
  // Step the cascade word; it must arrive after four register stages
  task automatic test_cascade();
    cas_word <= 16'h0100;
    run(WF, 6);
    cas_word <= 16'h0A50;
    push(WF);
    run(WF, 3);
    check({zpins, low}, exp_filt(1'b1, 16'h0100), "cascade early");
    push(WF);
    check({zpins, low}, exp_filt(1'b1, 16'h0A50), "cascade late");
  endtask : test_cascade

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  // Print the counts and the verdict, then stop
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // Free-running clock from time zero
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Watchdog well beyond the 120 or so cycles of the run
  initial begin
    #(3000 * 100);
    fails++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done();
  end
  // Main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    s_valid = 1'b0;
    hold = 1'b0;
    mode_sel = NMA_MATRIX;
    cwe = CWE_HOLD;
    kport = '0;
    words = '0;
    cas_word = 16'h0;
    for (int p = 0; p < 3; p++) begin
      for (int s = 0; s < 3; s++) coef[p][s] = 10'(8 * (3 * p + s + 1) + 3);
    end
    // Coefficients have no reset: load them during the three reset edges
    load_coefs();
    rst <= 1'b0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    check(16'({hi_oe_n, up_oe_n}), 16'h0, "enables after reset");
    check(16'(s_ready), 16'h1, "ready after reset");
    load_coefs();
    test_matrix();
    test_hold();
    test_filters();
    test_cascade();
    set_mode(NMA_MATRIX);
    test_done();
  end
endmodule : testbench
`default_nettype wire
